//--- common/can_rx_tx_buffer_control_pkg.sv
package can_rx_tx_buffer_control_pkg;
    localparam int          ID_W          = 29;
    localparam int          DATA_W        = 64;
    localparam int          TXB_COUNT     = 3;
    localparam int          TXB_BYTES     = 14;
    localparam logic [3:0]  TXB_LAST      = 4'hd;
    localparam int          FIFO_WIDTH    = 8;
    localparam int          FIFO_DEPTH    = 32;
    localparam logic [7:0]  RX_CNT_MAX    = 8'hff;
    localparam logic [7:0]  RX_WARN_LIM   = 8'h60;
    localparam logic [7:0]  PASSIVE_LIM   = 8'h7f;
    localparam logic [8:0]  TX_WARN_LIM   = 9'h060;
    localparam logic [8:0]  TX_PASS_LIM   = 9'h07f;
    localparam logic [8:0]  BUS_OFF_LIM   = 9'h0ff;
    localparam logic [8:0]  TX_CNT_MAX    = 9'h100;
    localparam logic [4:0]  SYNC_TQ       = 5'h01;
    localparam logic [4:0]  BIT_MIN_TQ    = 5'h08;
    localparam logic [1:0]  MCLK_DIV_LAST = 2'h3;
    localparam logic [2:0]  TX_FLAG_RST   = 3'h7;
    typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_WAIT} tx_state_t;
endpackage : can_rx_tx_buffer_control_pkg

//--- src/can_rx_tx_buffer_control.sv
`timescale 1ns/1ps
// ----------------------------------------
// Byte FIFO toward the protocol engine
// ----------------------------------------
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic             i_clk_en,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    wire              push = i_in_valid && o_in_ready && i_clk_en;
    wire              pop  = o_out_valid && i_out_ready && i_clk_en;
    assign o_in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_ff != '0);
    assign o_out_data  = mem_ff[rd_ff];
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_ff[wr_ff] <= i_in_data;
        end
    end
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : byte_fifo

// ----------------------------------------
// Buffer and error core
// ----------------------------------------
module can_rx_tx_buffer_control (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_clk_en,
    input  wire logic        i_mab_valid,
    input  wire logic [28:0] i_mab_id,
    input  wire logic [63:0] i_mab_data,
    input  wire logic [28:0] i_filter_0,
    input  wire logic [28:0] i_filter_1,
    input  wire logic [28:0] i_mask_0,
    input  wire logic [28:0] i_mask_1,
    input  wire logic        i_double_buffer_enable,
    input  wire logic [1:0]  i_rx_release,
    input  wire logic [1:0]  i_rx_flag_clear,
    input  wire logic [1:0]  i_rx_int_enable,
    input  wire logic        i_rx_error,
    input  wire logic        i_error_flags_clear,
    output logic [1:0]       o_rx_buffer_full,
    output logic [1:0]       o_rx_buffer_flag,
    output logic [1:0]       o_rx_overrun_flag,
    output logic [28:0]      o_receive_buffer_0_id,
    output logic [63:0]      o_receive_buffer_0_data,
    output logic [28:0]      o_receive_buffer_1_id,
    output logic [63:0]      o_receive_buffer_1_data,
    output logic             o_invalid_message_flag,
    output logic             o_error_summary_flag,
    output logic             o_rx_warning_flag,
    output logic             o_rx_error_passive_flag,
    output logic [7:0]       o_rx_error_count,
    output logic             o_rx_interrupt,
    output logic             o_error_interrupt,
    input  wire logic        i_txb_write,
    input  wire logic [1:0]  i_txb_select,
    input  wire logic [3:0]  i_txb_index,
    input  wire logic [7:0]  i_txb_byte,
    input  wire logic [5:0]  i_tx_priority_field,
    input  wire logic [2:0]  i_tx_request_set,
    input  wire logic [2:0]  i_tx_request_clear,
    input  wire logic        i_abort_all_pending,
    input  wire logic [2:0]  i_tx_buffer_int_enable,
    input  wire logic [2:0]  i_tx_flag_clear,
    output logic [2:0]       o_tx_request,
    output logic [2:0]       o_tx_aborted_flag,
    output logic [2:0]       o_tx_lost_arbitration_flag,
    output logic [2:0]       o_tx_error_flag,
    output logic [2:0]       o_tx_buffer_flag,
    output logic             o_tx_warning_flag,
    output logic             o_tx_error_passive_flag,
    output logic             o_bus_off_flag,
    output logic [8:0]       o_tx_error_count,
    output logic             o_tx_interrupt,
    output logic             o_tx_byte_valid,
    input  wire logic        i_tx_byte_ready,
    output logic [7:0]       o_tx_byte,
    input  wire logic        i_tx_done,
    input  wire logic        i_tx_lost_arb,
    input  wire logic        i_tx_bus_error,
    input  wire logic        i_module_clock_select,
    input  wire logic [5:0]  i_quantum_prescaler,
    input  wire logic [2:0]  i_prop_seg,
    input  wire logic [2:0]  i_phase1_seg,
    input  wire logic [2:0]  i_phase2_seg,
    output logic             o_quantum_tick,
    output logic             o_sample_tick,
    output logic             o_bit_tick
);
    // ----------------------------------------
    // Receive acceptance and buffering
    // ----------------------------------------
    logic [1:0]  full_ff;
    logic [1:0]  rxf_ff;
    logic [1:0]  ovr_ff;
    logic        inv_ff;
    logic        sum_ff;
    logic [7:0]  rxc_ff;
    logic [8:0]  txc_ff;
    logic [28:0] id0_ff;
    logic [28:0] id1_ff;
    logic [63:0] dat0_ff;
    logic [63:0] dat1_ff;
    wire hit0   = ((i_mab_id ^ i_filter_0) & i_mask_0) == '0;
    wire hit1   = ((i_mab_id ^ i_filter_1) & i_mask_1) == '0;
    wire for0   = i_mab_valid && hit0;
    wire for1   = i_mab_valid && !hit0 && hit1;
    wire spill  = for0 && full_ff[0] && i_double_buffer_enable;
    wire store0 = for0 && !full_ff[0];
    wire store1 = (for1 || spill) && !full_ff[1];
    wire over0  = for0 && full_ff[0] && !i_double_buffer_enable;
    wire over1  = (for1 || spill) && full_ff[1];
    wire [1:0] stored = {store1, store0};
    wire rx_warn  = rxc_ff >= can_rx_tx_buffer_control_pkg::RX_WARN_LIM;
    wire rx_pass  = rxc_ff > can_rx_tx_buffer_control_pkg::PASSIVE_LIM;
    wire tx_warn  = txc_ff > can_rx_tx_buffer_control_pkg::TX_WARN_LIM;
    wire tx_pass  = txc_ff > can_rx_tx_buffer_control_pkg::TX_PASS_LIM;
    wire bus_off  = txc_ff > can_rx_tx_buffer_control_pkg::BUS_OFF_LIM;
    // Level sources keep the summary up while they hold; clearing only drops history
    // Receive errors stay out of it, else each one would reach the error interrupt
    wire err_src  = over0 || over1 || i_tx_bus_error
                    || rx_warn || rx_pass || tx_warn || tx_pass || bus_off;
    wire rx_inc   = i_rx_error && (rxc_ff != can_rx_tx_buffer_control_pkg::RX_CNT_MAX);
    wire tx_inc   = i_tx_bus_error && (txc_ff != can_rx_tx_buffer_control_pkg::TX_CNT_MAX);
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            full_ff <= '0;
            rxf_ff  <= '0;
            ovr_ff  <= '0;
            inv_ff  <= 1'b0;
            sum_ff  <= 1'b0;
            rxc_ff  <= '0;
            txc_ff  <= '0;
        end else if (i_clk_en) begin
            full_ff <= stored | (full_ff & ~i_rx_release);
            rxf_ff  <= stored | (rxf_ff & ~i_rx_flag_clear);
            ovr_ff  <= {over1, over0} | (ovr_ff & {2{~i_error_flags_clear}});
            inv_ff  <= i_rx_error || (inv_ff && !i_error_flags_clear);
            sum_ff  <= err_src || (sum_ff && !i_error_flags_clear);
            rxc_ff  <= rxc_ff + 8'(rx_inc);
            txc_ff  <= txc_ff + 9'(tx_inc);
        end
    end
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            id0_ff  <= '0;
            dat0_ff <= '0;
            id1_ff  <= '0;
            dat1_ff <= '0;
        end else if (i_clk_en) begin
            if (store0) begin
                id0_ff  <= i_mab_id;
                dat0_ff <= i_mab_data;
            end
            if (store1) begin
                id1_ff  <= i_mab_id;
                dat1_ff <= i_mab_data;
            end
        end
    end
    assign o_rx_buffer_full        = full_ff;
    assign o_rx_buffer_flag        = rxf_ff;
    assign o_rx_overrun_flag       = ovr_ff;
    assign o_receive_buffer_0_id   = id0_ff;
    assign o_receive_buffer_0_data = dat0_ff;
    assign o_receive_buffer_1_id   = id1_ff;
    assign o_receive_buffer_1_data = dat1_ff;
    assign o_invalid_message_flag  = inv_ff;
    assign o_error_summary_flag    = sum_ff;
    assign o_rx_warning_flag       = rx_warn;
    assign o_rx_error_passive_flag = rx_pass;
    assign o_rx_error_count        = rxc_ff;
    assign o_tx_warning_flag       = tx_warn;
    assign o_tx_error_passive_flag = tx_pass;
    assign o_bus_off_flag          = bus_off;
    assign o_tx_error_count        = txc_ff;
    // Receive errors themselves raise nothing; only the warning level interrupts
    assign o_rx_interrupt    = |(rxf_ff & i_rx_int_enable);
    assign o_error_interrupt = sum_ff || rx_warn;

    // ----------------------------------------
    // Transmit buffers and scheduling
    // ----------------------------------------
    can_rx_tx_buffer_control_pkg::tx_state_t state_ff;
    logic [7:0] txm_ff [can_rx_tx_buffer_control_pkg::TXB_COUNT]
                       [can_rx_tx_buffer_control_pkg::TXB_BYTES];
    logic [2:0] req_ff;
    logic [2:0] abt_ff;
    logic [2:0] larb_ff;
    logic [2:0] terr_ff;
    logic [2:0] txf_ff;
    logic [1:0] sel_ff;
    logic [3:0] idx_ff;
    logic       cancel_ff;
    wire        fifo_ready;
    wire [2:0]  sc0 = {req_ff[0], i_tx_priority_field[1:0]};
    wire [2:0]  sc1 = {req_ff[1], i_tx_priority_field[3:2]};
    wire [2:0]  sc2 = {req_ff[2], i_tx_priority_field[5:4]};
    // Ties go to the lower buffer number
    wire [1:0]  win01  = (sc1 > sc0) ? 2'h1 : 2'h0;
    wire [2:0]  sc01   = (sc1 > sc0) ? sc1 : sc0;
    wire [1:0]  winner = (sc2 > sc01) ? 2'h2 : win01;
    wire        start  = (state_ff == can_rx_tx_buffer_control_pkg::TX_IDLE) && (|req_ff)
                         && !bus_off && !i_abort_all_pending;
    wire        finish = (state_ff == can_rx_tx_buffer_control_pkg::TX_WAIT)
                         && (i_tx_done || i_tx_lost_arb || i_tx_bus_error);
    wire        fail   = finish && !i_tx_done;
    wire        push   = (state_ff == can_rx_tx_buffer_control_pkg::TX_LOAD);
    wire        pushed = push && fifo_ready;
    wire        busy   = (state_ff != can_rx_tx_buffer_control_pkg::TX_IDLE);
    wire        cancel_now = busy && (i_abort_all_pending || i_tx_request_clear[sel_ff]);
    genvar b;
    generate
        for (b = 0; b < can_rx_tx_buffer_control_pkg::TXB_COUNT; b++) begin : g_txb
            wire mine   = busy && (sel_ff == 2'(b));
            wire fin_b  = finish && mine;
            wire done_b = fin_b && i_tx_done;
            wire drop_b = fin_b && fail && (cancel_ff || cancel_now);
            wire sw_b   = (i_tx_request_clear[b] || i_abort_all_pending) && !mine;
            wire abt_b  = drop_b || (sw_b && req_ff[b]);
            wire set_b  = i_tx_request_set[b];
            always_ff @(posedge i_clock) begin
                if (i_clk_en && i_txb_write && i_txb_select == 2'(b)) begin
                    txm_ff[b][i_txb_index] <= i_txb_byte;
                end
            end
            always_ff @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    req_ff[b]  <= 1'b0;
                    abt_ff[b]  <= 1'b0;
                    larb_ff[b] <= 1'b0;
                    terr_ff[b] <= 1'b0;
                    txf_ff[b]  <= can_rx_tx_buffer_control_pkg::TX_FLAG_RST[b];
                end else if (i_clk_en) begin
                    req_ff[b]  <= set_b || (req_ff[b] && !done_b && !drop_b && !sw_b);
                    abt_ff[b]  <= abt_b || (abt_ff[b] && !set_b);
                    larb_ff[b] <= (fin_b && i_tx_lost_arb) || (larb_ff[b] && !set_b);
                    terr_ff[b] <= (fin_b && i_tx_bus_error) || (terr_ff[b] && !set_b);
                    txf_ff[b]  <= done_b || (txf_ff[b] && !i_tx_flag_clear[b]);
                end
            end
        end
    endgenerate
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_ff  <= can_rx_tx_buffer_control_pkg::TX_IDLE;
            sel_ff    <= '0;
            idx_ff    <= '0;
            cancel_ff <= 1'b0;
        end else if (i_clk_en) begin
            unique case (state_ff)
                can_rx_tx_buffer_control_pkg::TX_IDLE: begin
                    cancel_ff <= 1'b0;
                    idx_ff    <= '0;
                    if (start) begin
                        sel_ff   <= winner;
                        state_ff <= can_rx_tx_buffer_control_pkg::TX_LOAD;
                    end
                end
                can_rx_tx_buffer_control_pkg::TX_LOAD: begin
                    cancel_ff <= cancel_ff || cancel_now;
                    if (pushed) begin
                        idx_ff <= idx_ff + 4'h1;
                        if (idx_ff == can_rx_tx_buffer_control_pkg::TXB_LAST) begin
                            state_ff <= can_rx_tx_buffer_control_pkg::TX_WAIT;
                        end
                    end
                end
                can_rx_tx_buffer_control_pkg::TX_WAIT: begin
                    cancel_ff <= cancel_ff || cancel_now;
                    if (finish) begin
                        state_ff <= can_rx_tx_buffer_control_pkg::TX_IDLE;
                    end
                end
            endcase
        end
    end
    byte_fifo #(
        .WIDTH (can_rx_tx_buffer_control_pkg::FIFO_WIDTH),
        .DEPTH (can_rx_tx_buffer_control_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_clk_en    (i_clk_en),
        .i_in_valid  (push),
        .o_in_ready  (fifo_ready),
        .i_in_data   (txm_ff[sel_ff][idx_ff]),
        .o_out_valid (o_tx_byte_valid),
        .i_out_ready (i_tx_byte_ready),
        .o_out_data  (o_tx_byte)
    );
    assign o_tx_request               = req_ff;
    assign o_tx_aborted_flag          = abt_ff;
    assign o_tx_lost_arbitration_flag = larb_ff;
    assign o_tx_error_flag            = terr_ff;
    assign o_tx_buffer_flag           = txf_ff;
    assign o_tx_interrupt = |(txf_ff & ~req_ff & i_tx_buffer_int_enable);

    // ----------------------------------------
    // Bit timing
    // ----------------------------------------
    logic [1:0] mdiv_ff;
    logic [6:0] pre_ff;
    logic [4:0] tq_ff;
    wire mclk = !i_module_clock_select
                || (mdiv_ff == can_rx_tx_buffer_control_pkg::MCLK_DIV_LAST);
    wire [6:0] pre_last = {i_quantum_prescaler, 1'b1};
    wire tq = mclk && (pre_ff == pre_last);
    wire [4:0] raw_len = can_rx_tx_buffer_control_pkg::SYNC_TQ + 5'(i_prop_seg)
                         + 5'(i_phase1_seg) + 5'(i_phase2_seg) + 5'h03;
    // Short settings stretch phase 2 so the bit never drops under the minimum
    wire [4:0] bit_len = (raw_len < can_rx_tx_buffer_control_pkg::BIT_MIN_TQ)
                         ? can_rx_tx_buffer_control_pkg::BIT_MIN_TQ : raw_len;
    wire [4:0] smp_at = can_rx_tx_buffer_control_pkg::SYNC_TQ + 5'(i_prop_seg)
                        + 5'(i_phase1_seg) + 5'h01;
    wire bit_end = tq && (tq_ff == bit_len - 5'h01);
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            mdiv_ff <= '0;
            pre_ff  <= '0;
            tq_ff   <= '0;
        end else if (i_clk_en) begin
            mdiv_ff <= mdiv_ff + 2'h1;
            if (mclk) begin
                pre_ff <= tq ? 7'h00 : pre_ff + 7'h01;
            end
            if (tq) begin
                tq_ff <= bit_end ? 5'h00 : tq_ff + 5'h01;
            end
        end
    end
    assign o_quantum_tick = tq && i_clk_en;
    assign o_sample_tick  = tq && i_clk_en && (tq_ff == smp_at - 5'h01);
    assign o_bit_tick     = bit_end && i_clk_en;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_pick;
        i_clk_en && start;
    endsequence
    sequence s_success;
        i_clk_en && finish && i_tx_done;
    endsequence
    property p_mask_zero;
        @(posedge i_clock) disable iff (i_rst)
        (i_clk_en && i_mab_valid && i_mask_0 == '0 && !full_ff[0]) |=> full_ff[0];
    endproperty
    a_mask_zero: assert property (p_mask_zero) else $error("Zero mask did not accept");
    property p_overrun;
        @(posedge i_clock) disable iff (i_rst)
        (i_clk_en && over0) |=> (ovr_ff[0] && sum_ff && id0_ff == $past(id0_ff));
    endproperty
    a_overrun: assert property (p_overrun) else $error("Overrun not flagged");
    property p_spill;
        @(posedge i_clock) disable iff (i_rst)
        (i_clk_en && spill && !full_ff[1]) |=> (full_ff[1] && ovr_ff[0] == $past(ovr_ff[0]));
    endproperty
    a_spill: assert property (p_spill) else $error("Double buffer spill wrong");
    property p_both_full;
        @(posedge i_clock) disable iff (i_rst)
        (i_clk_en && spill && full_ff[1]) |=> ovr_ff[1];
    endproperty
    a_both_full: assert property (p_both_full) else $error("Buffer 1 overrun missed");
    property p_rx_count;
        @(posedge i_clock) disable iff (i_rst)
        (i_clk_en && i_rx_error && rxc_ff < 8'h05) |=> (rxc_ff == $past(rxc_ff) + 8'h01);
    endproperty
    a_rx_count: assert property (p_rx_count) else $error("Receive count not bumped");
    property p_pick;
        @(posedge i_clock) disable iff (i_rst)
        s_pick |=> (sel_ff == $past(winner) && req_ff[sel_ff]);
    endproperty
    a_pick: assert property (p_pick) else $error("Wrong buffer chosen");
    property p_request;
        @(posedge i_clock) disable iff (i_rst)
        (i_clk_en && i_tx_request_set[0]) |=> (req_ff[0] && !abt_ff[0] && !terr_ff[0]);
    endproperty
    a_request: assert property (p_request) else $error("Request did not clear flags");
    property p_success;
        @(posedge i_clock) disable iff (i_rst)
        s_success ##0 (i_tx_request_set == '0) |=> (!req_ff[$past(sel_ff)] && txf_ff[$past(sel_ff)]);
    endproperty
    a_success: assert property (p_success) else $error("Completion not recorded");
    property p_abort_all;
        @(posedge i_clock) disable iff (i_rst)
        (i_clk_en && i_abort_all_pending && !busy && i_tx_request_set == '0) |=> (req_ff == '0);
    endproperty
    a_abort_all: assert property (p_abort_all) else $error("Abort all left a request");
    property p_bus_off;
        @(posedge i_clock) disable iff (i_rst)
        (bus_off && !busy) |=> !busy;
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("Sent while bus-off");
endmodule : can_rx_tx_buffer_control

//--- sim/can_engine_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Protocol engine stand-in: eats 14 bytes, then reports the attempt
// ----------------------------------------
module can_engine_model (
    input  wire logic       i_clock,
    input  wire logic       i_byte_valid,
    input  wire logic [1:0] i_mode,
    output logic            o_byte_ready = 1'h0,
    output logic [2:0]      o_result = 3'h0
);
    int n = 0;
    always @(posedge i_clock) begin
        o_result <= 3'h0;
        o_byte_ready <= 1'($urandom_range(1));
        if (i_byte_valid && o_byte_ready) n = n + 1;
        if (n == 14) begin
            n = 0;
            o_result <= 3'h4 >> i_mode; // Done, lost or bus error
        end
    end
endmodule : can_engine_model

//--- sim/can_rx_tx_buffer_control_tb.sv
`timescale 1ns/1ps
module can_rx_tx_buffer_control_tb;
    logic i_clock = 0, i_rst = 1, i_clk_en = 1, i_mab_valid = 0, i_rx_error = 0, i_txb_write = 0;
    logic i_double_buffer_enable = 0, i_error_flags_clear = 0, i_abort_all_pending = 0;
    logic i_tx_byte_ready, i_tx_done, i_tx_lost_arb, i_tx_bus_error, i_module_clock_select = 0;
    logic [1:0] i_rx_release = 0, i_rx_flag_clear = 0, i_rx_int_enable = 3, i_txb_select = 0;
    logic [2:0] i_tx_request_set = 0, i_tx_request_clear = 0, i_tx_buffer_int_enable = 7;
    logic [2:0] i_tx_flag_clear = 0, i_prop_seg = 1, i_phase1_seg = 1, i_phase2_seg = 1;
    logic [1:0] mode = 0, o_rx_buffer_full, o_rx_buffer_flag, o_rx_overrun_flag;
    logic [3:0] i_txb_index = 0;
    logic [5:0] i_tx_priority_field = 0, i_quantum_prescaler = 0;
    logic [7:0] i_txb_byte = 0, o_rx_error_count, o_tx_byte;
    logic [28:0] i_mab_id = 0, i_filter_0 = 5, i_filter_1 = 0, i_mask_0 = 'hf, i_mask_1 = 0;
    logic [28:0] o_receive_buffer_0_id, o_receive_buffer_1_id;
    logic [63:0] i_mab_data = 0, o_receive_buffer_0_data, o_receive_buffer_1_data;
    logic o_invalid_message_flag, o_error_summary_flag, o_rx_warning_flag, o_rx_interrupt;
    logic o_rx_error_passive_flag, o_error_interrupt, o_tx_warning_flag, o_tx_interrupt;
    logic o_tx_error_passive_flag, o_bus_off_flag, o_tx_byte_valid;
    logic o_quantum_tick, o_sample_tick, o_bit_tick;
    logic [2:0] o_tx_request, o_tx_aborted_flag, o_tx_lost_arbitration_flag, o_tx_error_flag;
    logic [2:0] o_tx_buffer_flag;
    logic [8:0] o_tx_error_count;
    wire [11:0] tx_now = {o_tx_warning_flag, o_tx_error_passive_flag, o_bus_off_flag,
                          o_tx_error_count};
    logic [63:0] d;
    logic [7:0] tx0 [14];
    int p = 0;
    int lim [6] = '{96, 97, 127, 128, 255, 256};
    int errors = 0, total_checks = 0;
    always #2 i_clock = ~i_clock;
    can_rx_tx_buffer_control dut (.*);
    can_engine_model far (.i_clock(i_clock), .i_byte_valid(o_tx_byte_valid), .i_mode(mode),
        .o_byte_ready(i_tx_byte_ready), .o_result({i_tx_done, i_tx_lost_arb, i_tx_bus_error}));
    task automatic step(input int n = 1);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : step
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Any identifier whose masked nibble equals filter 0 belongs to buffer 0
    function automatic logic [28:0] to_b0(input logic [28:0] r);
        return {r[28:4], i_filter_0[3:0]};
    endfunction : to_b0
    task automatic pulse(ref logic s, input int n);
        repeat (n) begin
            s = 1;
            step;
            s = 0;
            step;
        end
    endtask : pulse
    task automatic msg(input logic [28:0] x);
        i_mab_id = x;
        i_mab_data = {$urandom, $urandom};
        pulse(i_mab_valid, 1);
    endtask : msg
    task automatic req(input logic [2:0] m);
        i_tx_request_set = m;
        step;
        i_tx_request_set = 3'h0;
        step;
    endtask : req
    // Quanta per bit: sync plus three segments, each held as length minus one
    function automatic int bit_quanta();
        int len = 4 + i_prop_seg + i_phase1_seg + i_phase2_seg;
        return (len < 8) ? 8 : len;
    endfunction : bit_quanta
    function automatic logic [11:0] tx_state(input int c);
        return {c > 96, c > 127, c > 255, 9'(c)};
    endfunction : tx_state
    // One setting only: shrinking it later could let the counters wrap first
    task automatic bit_time();
        int n = 0, q = 0, s = 0, t;
        i_quantum_prescaler = 6'($urandom_range(7));
        i_module_clock_select = 1'($urandom_range(1));
        {i_prop_seg, i_phase1_seg, i_phase2_seg} = 9'($urandom);
        for (int k = 0; k < 2000 && !o_bit_tick; k++) step;
        step;
        for (int k = 0; k < 2000 && !o_bit_tick; k++) begin
            n++;
            q += o_quantum_tick;
            s += o_sample_tick;
            step;
        end
        t = bit_quanta() * 2 * (i_quantum_prescaler + 1);
        if (i_module_clock_select) t = t * 4;
        chk(n + 1, t);
        chk(q + 1, bit_quanta());
        chk(s, 1);
    endtask : bit_time
    task automatic end_of_test();
        $display("errors=%0d checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
    initial begin
        void'($urandom(3855));
        step(12);
        i_rst = 0;
        chk({o_tx_interrupt, o_tx_buffer_flag}, 4'hf);
        msg(to_b0($urandom));
        d = i_mab_data;
        chk(o_receive_buffer_0_data, d);
        chk({o_rx_interrupt, o_rx_buffer_flag}, 3'h5);
        msg(to_b0($urandom));
        chk(o_receive_buffer_0_data, d);
        chk(o_rx_buffer_full, 2'h1);
        chk({o_error_interrupt, o_error_summary_flag, o_rx_overrun_flag}, 4'hd);
        i_rx_release = 2'h3;
        i_double_buffer_enable = 1;
        pulse(i_error_flags_clear, 1);
        i_rx_release = 2'h0;
        repeat (2) msg(to_b0($urandom));
        chk({o_rx_overrun_flag, o_rx_buffer_full}, 4'h3);
        chk(o_receive_buffer_1_data, i_mab_data);
        msg(to_b0($urandom) ^ 29'h10); // Unmasked bit differs, still aimed at buffer 0
        chk(o_rx_overrun_flag, 2'h2);
        pulse(i_error_flags_clear, 1);
        pulse(i_rx_error, 95);
        chk({o_error_interrupt, o_rx_warning_flag, o_rx_error_count}, 10'h05f);
        pulse(i_rx_error, 1);
        chk({o_rx_warning_flag, o_invalid_message_flag, o_rx_error_count}, 10'h360);
        chk(o_error_interrupt, 1'h1);
        pulse(i_rx_error, 31);
        chk({o_rx_error_passive_flag, o_rx_error_count}, 9'h07f);
        pulse(i_rx_error, 1);
        chk({o_rx_error_passive_flag, o_rx_error_count}, 9'h180);
        for (int i = 0; i < 14; i++) begin
            i_txb_write = 1;
            i_txb_index = 4'(i);
            i_txb_byte = 8'($urandom);
            tx0[i] = i_txb_byte;
            step;
        end
        i_txb_write = 0;
        i_tx_flag_clear = 3'h7;
        step;
        i_tx_flag_clear = 3'h0;
        chk({o_tx_interrupt, o_tx_buffer_flag}, 4'h0);
        req(3'h1);
        for (int k = 0; k < 300 && o_tx_request[0]; k++) begin
            if (o_tx_byte_valid && i_tx_byte_ready) begin
                chk(o_tx_byte, tx0[p]);
                p++;
            end
            step;
        end
        chk(p, 14);
        chk({o_tx_request, o_tx_aborted_flag}, 6'h0);
        chk({o_tx_interrupt, o_tx_buffer_flag}, 4'h9);
        mode = 2'h1;
        i_tx_priority_field = 6'h1c;
        req(3'h6);
        for (int k = 0; k < 300 && o_tx_lost_arbitration_flag == 0; k++) step;
        chk({o_tx_request, o_tx_lost_arbitration_flag}, 6'h32);
        pulse(i_abort_all_pending, 1);
        for (int k = 0; k < 300 && o_tx_request != 0; k++) step;
        chk({o_tx_aborted_flag, o_tx_buffer_flag}, 6'h31);
        req(3'h2);
        chk(o_tx_aborted_flag, 3'h4);
        mode = 2'h2;
        foreach (lim[i]) begin
            for (int k = 0; k < 12000 && o_tx_error_count < lim[i]; k++) step;
            chk(tx_now, tx_state(lim[i]));
        end
        chk({o_tx_request, o_tx_error_flag}, 6'h12);
        bit_time();
        end_of_test();
    end
endmodule : can_rx_tx_buffer_control_tb
